// ### irq_bank_pkg.sv
// constants, register map and field layout of the peripheral interrupt flag bank
// Functional notes
// - bit 7 flag sets when wave generator b enters shutdown.
// - bit 6 flag sets when wave generator a enters shutdown.
// - bit 5 flag sets when timer five gate closes.
// - bit 4 flag sets on timer five overflow, held until software clears.
// - capture mode: unit flag bits 3..0 set on capture, software clears.
// - compare mode: unit flag sets on compare match, held until cleared.
// - pwm mode: unit flag sets on output trailing edge, held until cleared.
// - flags set on events regardless of enable bits and global enable.
// - request group four bits read, write, hardware set; reset to zero.
// - unimplemented bits in control, enable and flag registers read zero.
// - wake request whenever an enabled group zero condition exists, or one in groups one to four with peripheral enable set, even with global enable off.
package irq_bank_pkg;
	localparam int        ADDR_W          = 4;
	localparam int        DATA_W          = 8;
	localparam int        NUM_GROUPS      = 5;
	// register indices
	localparam logic [3:0] ADDR_GLOBAL_CTRL = 4'h0;
	localparam logic [3:0] ADDR_ENABLE_BASE = 4'h1;
	localparam logic [3:0] ADDR_REQUEST_BASE = 4'h6;
	localparam logic [3:0] ADDR_IRQ_STATUS  = 4'hb;
	localparam logic [3:0] ADDR_IRQ_CLEAR   = 4'hc;
	localparam logic [3:0] ADDR_IRQ_ENABLE  = 4'hd;
	// implemented-bit masks
	localparam logic [7:0] GLOBAL_CTRL_MASK = 8'hc1;
	localparam logic [7:0] GROUP0_MASK      = 8'h31;
	localparam logic [7:0] GROUP_FULL_MASK  = 8'hff;
	// global control fields
	localparam int        GLOBAL_EN_BIT   = 7;
	localparam int        PERIPH_EN_BIT   = 6;
	localparam int        EDGE_SEL_BIT    = 0;
	// request group four fields
	localparam int        WAVEGEN_B_BIT   = 7;
	localparam int        WAVEGEN_A_BIT   = 6;
	localparam int        T5_GATE_BIT     = 5;
	localparam int        T5_OVF_BIT      = 4;
	localparam int        NUM_CCP         = 4;
	// bank event status fields
	localparam int        EVT_CORE_BIT    = 0;
	localparam int        EVT_WAKE_BIT    = 1;
	localparam int        EVT_W           = 2;
	localparam logic [7:0] REG_RESET       = 8'h00;
	localparam logic [1:0] CCP_MODE_CAPTURE = 2'h0;
	localparam logic [1:0] CCP_MODE_COMPARE = 2'h1;
	localparam logic [1:0] CCP_MODE_PWM     = 2'h2;
endpackage : irq_bank_pkg

// ### ccp_event_select.sv
`timescale 1ns/100ps
// picks the event that sets one capture/compare/pwm unit flag from its mode
module ccp_event_select
	import irq_bank_pkg::*;
(
	// mode and events
	input  wire logic [1:0] ccp_mode_select,
	input  wire logic       capture_evt,
	input  wire logic       compare_evt,
	input  wire logic       pwm_trail_evt,
	// chosen event
	output logic            flag_set
);
	always_comb begin
		unique case (ccp_mode_select)
			CCP_MODE_CAPTURE: flag_set = capture_evt;
			CCP_MODE_COMPARE: flag_set = compare_evt;
			CCP_MODE_PWM:     flag_set = pwm_trail_evt;
			default:          flag_set = 1'b0;
		endcase
	end
endmodule : ccp_event_select

// ### peripheral_irq_flag_bank.sv
`timescale 1ns/100ps
// peripheral interrupt flag and enable bank with core request and wake outputs
module peripheral_irq_flag_bank
	import irq_bank_pkg::*;
#(
	parameter int NUM_UNITS = NUM_CCP
)
(
	// clock and reset
	input  wire logic                clk_sys,
	input  wire logic                reset_n,
	// register port
	input  wire logic [ADDR_W-1:0]   reg_addr,
	input  wire logic [DATA_W-1:0]   reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [DATA_W-1:0]   reg_rdata,
	// set pulses for the other request groups
	input  wire logic [DATA_W-1:0]   group0_set,
	input  wire logic [DATA_W-1:0]   group1_set,
	input  wire logic [DATA_W-1:0]   group2_set,
	input  wire logic [DATA_W-1:0]   group3_set,
	// group four event sources
	input  wire logic                wavegen_b_shutdown,
	input  wire logic                wavegen_a_shutdown,
	input  wire logic                timer_five_gate_close,
	input  wire logic                timer_five_overflow,
	input  wire logic [2*NUM_UNITS-1:0] ccp_mode_select,
	input  wire logic [NUM_UNITS-1:0] ccp_capture,
	input  wire logic [NUM_UNITS-1:0] ccp_compare,
	input  wire logic [NUM_UNITS-1:0] ccp_pwm_trail,
	// requests
	output logic                     core_irq_req,
	output logic                     wake_req,
	output logic                     external_irq_edge_select,
	output logic                     bank_irq
);
	// the low nibble of group four has room for four units only
	if (NUM_UNITS != NUM_CCP) begin : g_bad_units
		$error("NUM_UNITS must equal the four bits of group four");
	end

	logic [DATA_W-1:0] global_ctrl_r;
	logic [DATA_W-1:0] enable_r  [NUM_GROUPS];
	logic [DATA_W-1:0] request_r [NUM_GROUPS];
	logic [DATA_W-1:0] hw_set    [NUM_GROUPS];
	logic [NUM_UNITS-1:0] ccp_set;
	logic [EVT_W-1:0]  evt_status_r;
	logic [EVT_W-1:0]  evt_enable_r;
	logic              core_irq_q;
	logic              wake_q;

	// implemented bits of a group register
	function automatic logic [DATA_W-1:0] group_mask(input int g);
		group_mask = (g == 0) ? GROUP0_MASK : GROUP_FULL_MASK;
	endfunction : group_mask

	genvar u;
	generate
		for (u = 0; u < NUM_UNITS; u++) begin : g_ccp
			ccp_event_select u_sel (
				.ccp_mode_select (ccp_mode_select[2*u +: 2]),
				.capture_evt     (ccp_capture[u]),
				.compare_evt     (ccp_compare[u]),
				.pwm_trail_evt   (ccp_pwm_trail[u]),
				.flag_set        (ccp_set[u])
			);
		end
	endgenerate

	always_comb begin
		hw_set[0] = group0_set;
		hw_set[1] = group1_set;
		hw_set[2] = group2_set;
		hw_set[3] = group3_set;
		hw_set[4] = '0;
		hw_set[4][WAVEGEN_B_BIT] = wavegen_b_shutdown;
		hw_set[4][WAVEGEN_A_BIT] = wavegen_a_shutdown;
		hw_set[4][T5_GATE_BIT]   = timer_five_gate_close;
		hw_set[4][T5_OVF_BIT]    = timer_five_overflow;
		hw_set[4][NUM_UNITS-1:0] = ccp_set;
	end

	// global control register
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			global_ctrl_r <= REG_RESET;
		end else if (reg_wr && reg_addr == ADDR_GLOBAL_CTRL) begin
			global_ctrl_r <= reg_wdata & GLOBAL_CTRL_MASK;
		end
	end
	assign external_irq_edge_select = global_ctrl_r[EDGE_SEL_BIT];

	// enable and request groups
	genvar g;
	generate
		for (g = 0; g < NUM_GROUPS; g++) begin : g_grp
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					enable_r[g] <= REG_RESET;
				end else if (reg_wr && reg_addr == ADDR_ENABLE_BASE + 4'(g)) begin
					enable_r[g] <= reg_wdata & group_mask(g);
				end
			end
			// rw and hardware set; set ignores enables, set wins over write
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					request_r[g] <= REG_RESET;
				end else if (reg_wr && reg_addr == ADDR_REQUEST_BASE + 4'(g)) begin
					request_r[g] <= (reg_wdata | hw_set[g]) & group_mask(g);
				end else begin
					request_r[g] <= (request_r[g] | hw_set[g]) & group_mask(g);
				end
			end
		end
	endgenerate

	// pending enabled conditions
	logic pend_direct;
	logic pend_periph;
	always_comb begin
		pend_direct = |(request_r[0] & enable_r[0]);
		pend_periph = 1'b0;
		for (int k = 1; k < NUM_GROUPS; k++) begin
			pend_periph = pend_periph | (|(request_r[k] & enable_r[k]));
		end
	end

	assign core_irq_q = global_ctrl_r[GLOBAL_EN_BIT] &
		(pend_direct | (global_ctrl_r[PERIPH_EN_BIT] & pend_periph));
	assign wake_q = pend_direct | (global_ctrl_r[PERIPH_EN_BIT] & pend_periph);
	assign core_irq_req = core_irq_q;
	assign wake_req     = wake_q;

	// bank event status, set wins over clear
	logic [EVT_W-1:0] evt_in;
	logic [EVT_W-1:0] evt_clr;
	assign evt_in  = {wake_q, core_irq_q};
	assign evt_clr = (reg_wr && reg_addr == ADDR_IRQ_CLEAR) ? reg_wdata[EVT_W-1:0] : '0;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			evt_status_r <= '0;
		end else begin
			evt_status_r <= (evt_status_r & ~evt_clr) | evt_in;
		end
	end
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			evt_enable_r <= '0;
		end else if (reg_wr && reg_addr == ADDR_IRQ_ENABLE) begin
			evt_enable_r <= reg_wdata[EVT_W-1:0];
		end
	end
	assign bank_irq = |(evt_status_r & evt_enable_r);

	// read port; unimplemented bits and addresses read zero
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			if (reg_addr == ADDR_GLOBAL_CTRL)
				reg_rdata <= global_ctrl_r;
			else if (reg_addr >= ADDR_ENABLE_BASE && reg_addr < ADDR_REQUEST_BASE)
				reg_rdata <= enable_r[3'(reg_addr - ADDR_ENABLE_BASE)];
			else if (reg_addr >= ADDR_REQUEST_BASE && reg_addr < ADDR_IRQ_STATUS)
				reg_rdata <= request_r[3'(reg_addr - ADDR_REQUEST_BASE)];
			else if (reg_addr == ADDR_IRQ_STATUS)
				reg_rdata <= {{(DATA_W-EVT_W){1'b0}}, evt_status_r};
			else if (reg_addr == ADDR_IRQ_ENABLE)
				reg_rdata <= {{(DATA_W-EVT_W){1'b0}}, evt_enable_r};
			else
				reg_rdata <= '0;
		end else begin
			reg_rdata <= '0;
		end
	end

	// group four write strobe, shared by the checks below
	logic wr_req4;
	assign wr_req4 = reg_wr && reg_addr == ADDR_REQUEST_BASE + 4'h4;

	// checks
	// overflow sets flag next cycle
	a_ovf_sets_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
		timer_five_overflow |=> request_r[4][T5_OVF_BIT])
		else $error("overflow flag not set");
	a_wgb_sets_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
		wavegen_b_shutdown |=> request_r[4][WAVEGEN_B_BIT])
		else $error("wavegen b flag not set");
	a_wga_sets_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
		wavegen_a_shutdown |=> request_r[4][WAVEGEN_A_BIT])
		else $error("wavegen a flag not set");
	a_gate_sets_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
		timer_five_gate_close |=> request_r[4][T5_GATE_BIT])
		else $error("gate flag not set");
	a_cap_sets_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(ccp_mode_select[1:0] == CCP_MODE_CAPTURE && ccp_capture[0]) |=> request_r[4][0])
		else $error("capture flag not set");
	a_cmp_sets_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(ccp_mode_select[3:2] == CCP_MODE_COMPARE && ccp_compare[1]) |=> request_r[4][1])
		else $error("compare flag not set");
	a_pwm_sets_flag: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(ccp_mode_select[5:4] == CCP_MODE_PWM && ccp_pwm_trail[2]) |=> request_r[4][2])
		else $error("pwm flag not set");
	a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(request_r[4][T5_OVF_BIT] && !(reg_wr && reg_addr == ADDR_REQUEST_BASE + 4'h4))
		|=> request_r[4][T5_OVF_BIT])
		else $error("flag dropped without write");
	a_write_clears: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(reg_wr && reg_addr == ADDR_REQUEST_BASE + 4'h4 && reg_wdata == 8'h00 && hw_set[4] == 8'h00)
		|=> request_r[4] == 8'h00)
		else $error("write did not clear");
	a_unimpl_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(reg_rd && reg_addr == ADDR_REQUEST_BASE) |=> (reg_rdata & ~GROUP0_MASK) == 8'h00)
		else $error("unimplemented bit read one");
	a_wake_no_gie: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(|(request_r[0] & enable_r[0])) |-> wake_req)
		else $error("wake missing");
	a_core_needs_gie: assert property (@(posedge clk_sys) disable iff (!reset_n)
		core_irq_req |-> (global_ctrl_r[GLOBAL_EN_BIT] && wake_req))
		else $error("core request without global enable");
	a_set_no_enable: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(!global_ctrl_r[GLOBAL_EN_BIT] && enable_r[4] == 8'h00 && wavegen_b_shutdown)
		|=> request_r[4][WAVEGEN_B_BIT])
		else $error("flag not set with enables off");
	a_gate_no_enable: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(enable_r[4] == 8'h00 && timer_five_gate_close) |=> request_r[4][T5_GATE_BIT])
		else $error("gate flag not set with enables off");
	a_set_wins_write: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(wr_req4 && timer_five_overflow) |=> request_r[4][T5_OVF_BIT])
		else $error("event lost against a write");
	a_req4_sticky: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!wr_req4 |=> (request_r[4] & $past(request_r[4])) == $past(request_r[4]))
		else $error("group four flag dropped without write");
	a_req4_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(!wr_req4 && hw_set[4] == 8'h00) |=> request_r[4] == $past(request_r[4]))
		else $error("group four changed without event");
	a_req4_readback: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(reg_rd && reg_addr == ADDR_REQUEST_BASE + 4'h4) |=> reg_rdata == $past(request_r[4]))
		else $error("group four read wrong");
	a_ctrl_mask: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(global_ctrl_r & ~GLOBAL_CTRL_MASK) == 8'h00)
		else $error("control unimplemented bit set");
	a_group0_mask: assert property (@(posedge clk_sys) disable iff (!reset_n)
		((request_r[0] | enable_r[0]) & ~GROUP0_MASK) == 8'h00)
		else $error("group zero unimplemented bit set");
	a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(reg_rd && reg_addr > ADDR_IRQ_ENABLE) |=> reg_rdata == 8'h00)
		else $error("unmapped index read nonzero");
	a_clear_reads_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(reg_rd && reg_addr == ADDR_IRQ_CLEAR) |=> reg_rdata == 8'h00)
		else $error("clear register read nonzero");
	a_status_upper: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(reg_rd && reg_addr == ADDR_IRQ_STATUS) |=> reg_rdata[DATA_W-1:EVT_W] == '0)
		else $error("status upper bits nonzero");
	a_wake_periph: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(!global_ctrl_r[GLOBAL_EN_BIT] && global_ctrl_r[PERIPH_EN_BIT] && |(request_r[4] & enable_r[4]))
		|-> wake_req)
		else $error("peripheral wake missing");
	a_wake_gated: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(!global_ctrl_r[PERIPH_EN_BIT] && !(|(request_r[0] & enable_r[0]))) |-> !wake_req)
		else $error("wake without enabled condition");
	a_wake_seen: assert property (@(posedge clk_sys) disable iff (!reset_n)
		wake_req |=> evt_status_r[EVT_WAKE_BIT])
		else $error("wake not recorded");
	a_core_gated: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(!global_ctrl_r[PERIPH_EN_BIT] && !(|(request_r[0] & enable_r[0]))) |-> !core_irq_req)
		else $error("core request without enabled condition");
	a_core_direct: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(global_ctrl_r[GLOBAL_EN_BIT] && |(request_r[0] & enable_r[0])) |-> core_irq_req)
		else $error("core request missing");
	a_core_seen: assert property (@(posedge clk_sys) disable iff (!reset_n)
		core_irq_req |=> evt_status_r[EVT_CORE_BIT])
		else $error("core request not recorded");
	a_seen_cleared: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(reg_wr && reg_addr == ADDR_IRQ_CLEAR && reg_wdata[EVT_CORE_BIT] && !core_irq_req)
		|=> !evt_status_r[EVT_CORE_BIT])
		else $error("recorded request not cleared");
	a_edge_sel: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(reg_wr && reg_addr == ADDR_GLOBAL_CTRL) |=> external_irq_edge_select == $past(reg_wdata[EDGE_SEL_BIT]))
		else $error("edge select not written");

	for (genvar v = 0; v < NUM_UNITS; v++) begin : g_unit_chk
		a_unit_capture: assert property (@(posedge clk_sys) disable iff (!reset_n)
			(ccp_mode_select[2*v +: 2] == CCP_MODE_CAPTURE && ccp_capture[v]) |=> request_r[4][v])
			else $error("unit capture flag not set");
		a_unit_compare: assert property (@(posedge clk_sys) disable iff (!reset_n)
			(ccp_mode_select[2*v +: 2] == CCP_MODE_COMPARE && ccp_compare[v]) |=> request_r[4][v])
			else $error("unit compare flag not set");
		a_unit_pwm: assert property (@(posedge clk_sys) disable iff (!reset_n)
			(ccp_mode_select[2*v +: 2] == CCP_MODE_PWM && ccp_pwm_trail[v]) |=> request_r[4][v])
			else $error("unit pwm flag not set");
		a_unit_quiet: assert property (@(posedge clk_sys) disable iff (!reset_n)
			(!ccp_set[v] && !request_r[4][v] && !wr_req4) |=> !request_r[4][v])
			else $error("unit flag set without its event");
	end

	c_overflow_irq: cover property (@(posedge clk_sys) disable iff (!reset_n)
		timer_five_overflow ##[1:4] core_irq_req);
	c_wake_only: cover property (@(posedge clk_sys) disable iff (!reset_n)
		wake_req && !core_irq_req);
	c_bank_irq: cover property (@(posedge clk_sys) disable iff (!reset_n)
		bank_irq);
	c_ccp_flag: cover property (@(posedge clk_sys) disable iff (!reset_n)
		(|ccp_set) ##1 (|request_r[4][NUM_UNITS-1:0]));
	c_set_clash: cover property (@(posedge clk_sys) disable iff (!reset_n)
		wr_req4 && hw_set[4] != 8'h00);
endmodule : peripheral_irq_flag_bank

// ### event_source_model.sv
// event source model: pulses the bank's set inputs one cycle after a command
`timescale 1ns/100ps
module event_source_model
	import irq_bank_pkg::*;
(
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       reset_n,
	// command from the bench
	input  wire logic       fire,
	input  wire logic [2:0] grp,
	input  wire logic [1:0] kind,
	input  wire logic [7:0] mask,
	// pulses toward the bank
	output logic      [7:0] group0_set,
	output logic      [7:0] group1_set,
	output logic      [7:0] group2_set,
	output logic      [7:0] group3_set,
	output logic            wavegen_b_shutdown,
	output logic            wavegen_a_shutdown,
	output logic            timer_five_gate_close,
	output logic            timer_five_overflow,
	output logic      [3:0] ccp_capture,
	output logic      [3:0] ccp_compare,
	output logic      [3:0] ccp_pwm_trail
);
	logic [7:0] pulse_r [0:4];
	logic [1:0] kind_r;

	// single-cycle pulses, like real peripheral events; nothing is held between them
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < 5; i++)
				pulse_r[i] <= 8'h00;
			kind_r <= 2'h0;
		end else begin
			for (int i = 0; i < 5; i++)
				pulse_r[i] <= (fire && int'(grp) == i) ? mask : 8'h00;
			kind_r <= kind;
		end
	end

	assign group0_set            = pulse_r[0];
	assign group1_set            = pulse_r[1];
	assign group2_set            = pulse_r[2];
	assign group3_set            = pulse_r[3];
	assign wavegen_b_shutdown    = pulse_r[4][7];
	assign wavegen_a_shutdown    = pulse_r[4][6];
	assign timer_five_gate_close = pulse_r[4][5];
	assign timer_five_overflow   = pulse_r[4][4];
	// one kind at a time, so a unit sees only the event the bench names
	assign ccp_capture   = (kind_r == CCP_MODE_CAPTURE) ? pulse_r[4][3:0] : 4'h0;
	assign ccp_compare   = (kind_r == CCP_MODE_COMPARE) ? pulse_r[4][3:0] : 4'h0;
	assign ccp_pwm_trail = (kind_r == CCP_MODE_PWM) ? pulse_r[4][3:0] : 4'h0;
endmodule : event_source_model

// ### testbench.sv
// self-checking bench for the peripheral interrupt flag bank
`timescale 1ns/100ps
module testbench
	import irq_bank_pkg::*;
;
	logic       clk_sys = 1'b0;
	logic       reset_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_wr = 1'b0;
	logic       reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic       fire = 1'b0;
	logic [2:0] grp = 3'h0;
	logic [1:0] kind = 2'h0;
	logic [7:0] mask = 8'h00;
	logic [7:0] ccp_mode_select = 8'h00;
	logic [7:0] g0_set, g1_set, g2_set, g3_set, ccp_exp;
	logic       wg_b, wg_a, t5_gate, t5_ovf, core_irq_req, wake_req, edge_sel, bank_irq;
	logic [3:0] cap, cmp, pwm;
	int         n_fail = 0;
	int         checks = 0;
	int         cycles = 0;

	always #5 clk_sys = ~clk_sys;

	peripheral_irq_flag_bank #(.NUM_UNITS(4)) peripheral_irq_flag_bank_inst (
		.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .group0_set(g0_set),
		.group1_set(g1_set), .group2_set(g2_set), .group3_set(g3_set), .wavegen_b_shutdown(wg_b),
		.wavegen_a_shutdown(wg_a), .timer_five_gate_close(t5_gate), .timer_five_overflow(t5_ovf),
		.ccp_mode_select(ccp_mode_select), .ccp_capture(cap), .ccp_compare(cmp), .ccp_pwm_trail(pwm),
		.core_irq_req(core_irq_req), .wake_req(wake_req), .external_irq_edge_select(edge_sel),
		.bank_irq(bank_irq));
	event_source_model event_source_model_inst (
		.clk_sys(clk_sys), .reset_n(reset_n), .fire(fire), .grp(grp), .kind(kind), .mask(mask),
		.group0_set(g0_set), .group1_set(g1_set), .group2_set(g2_set), .group3_set(g3_set),
		.wavegen_b_shutdown(wg_b), .wavegen_a_shutdown(wg_a), .timer_five_gate_close(t5_gate),
		.timer_five_overflow(t5_ovf), .ccp_capture(cap), .ccp_compare(cmp), .ccp_pwm_trail(pwm));

	task automatic chk(input string what, input logic [7:0] e, input logic [7:0] got);
		checks++;
		if (got !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, e, got);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stand only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [3:0] a, input logic [7:0] e, input string what);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(what, e, reg_rdata);
	endtask : rd

	task automatic ev(input logic [2:0] g, input logic [1:0] k, input logic [7:0] m, input logic [7:0] md);
		@(posedge clk_sys);
		grp <= g;
		kind <= k;
		mask <= m;
		ccp_mode_select <= md;
		fire <= 1'b1;
		@(posedge clk_sys);
		fire <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask : ev

	task automatic outs(input logic [7:0] e);
		// a write lands at the edge just passed; let its registers settle
		#1;
		chk("core wake bank edge", e, {4'h0, core_irq_req, wake_req, bank_irq, edge_sel});
	endtask : outs

	task automatic complete_run;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run

	// whole run needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			complete_run();
		end
	end

	initial begin
		repeat (6) @(posedge clk_sys);
		reset_n <= 1'b1;
		for (int a = 0; a < 16; a++)
			rd(4'(a), 8'h00, "reset value");
		for (int a = 0; a < 11; a++) begin
			wr(4'(a), 8'hff);
			rd(4'(a), (a == 0) ? 8'hc1 : (a == 1 || a == 6) ? 8'h31 : 8'hff, "masked readback");
		end
		outs(8'h0d);
		for (int a = 10; a > 0; a--)
			wr(4'(a), 8'h00);
		wr(ADDR_GLOBAL_CTRL, 8'h00);
		rd(ADDR_IRQ_STATUS, 8'h03, "status");
		wr(ADDR_IRQ_ENABLE, 8'h03);
		outs(8'h02);
		wr(ADDR_IRQ_CLEAR, 8'h01);
		rd(ADDR_IRQ_STATUS, 8'h02, "status");
		wr(ADDR_IRQ_CLEAR, 8'h02);
		outs(8'h00);
		wr(ADDR_IRQ_ENABLE, 8'h00);
		for (int g = 0; g < 4; g++) begin
			ev(3'(g), 2'h0, 8'hff, 8'hff);
			rd(ADDR_REQUEST_BASE + 4'(g), (g == 0) ? 8'h31 : 8'hff, "group flags");
			wr(ADDR_REQUEST_BASE + 4'(g), 8'h00);
		end
		for (int b = 4; b < 8; b++) begin
			ev(3'h4, 2'h3, 8'(1 << b), 8'hff);
			rd(ADDR_REQUEST_BASE + 4'h4, 8'(1 << b), "group four flag");
			outs(8'h00);
			wr(ADDR_REQUEST_BASE + 4'h4, 8'h00);
			rd(ADDR_REQUEST_BASE + 4'h4, 8'h00, "cleared flag");
		end
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 3; k++) begin
				for (int u = 0; u < 4; u++)
					ccp_exp[u] = ((m + u) % 4 == k);
				ccp_exp[7:4] = 4'h0;
				ev(3'h4, 2'(k), 8'h0f, {2'(m + 3), 2'(m + 2), 2'(m + 1), 2'(m)});
				rd(ADDR_REQUEST_BASE + 4'h4, ccp_exp, "ccp flags");
				wr(ADDR_REQUEST_BASE + 4'h4, 8'h00);
			end
		end
		wr(ADDR_ENABLE_BASE + 4'h4, 8'h10);
		ev(3'h4, 2'h3, 8'h10, 8'hff);
		outs(8'h00);
		wr(ADDR_GLOBAL_CTRL, 8'h40);
		outs(8'h04);
		wr(ADDR_GLOBAL_CTRL, 8'hc0);
		outs(8'h0c);
		wr(ADDR_REQUEST_BASE + 4'h4, 8'h00);
		outs(8'h00);
		wr(ADDR_GLOBAL_CTRL, 8'h80);
		wr(ADDR_ENABLE_BASE, 8'h01);
		ev(3'h0, 2'h0, 8'h01, 8'hff);
		outs(8'h0c);
		wr(ADDR_REQUEST_BASE, 8'h00);
		outs(8'h00);
		complete_run();
	end
endmodule : testbench
